/* File: core/oscpd_ctrl.sv */
// Oscillator selection, sub-clock source and sleep/power-down control
// What this block does
// - Threshold bit one picks low brown-out level, zero picks high level.
// - Sub-clock is selected clock over 16, except code 00 uses 32 kHz.
// - Select codes pair RC1 with external, RC2, 4 MHz or 32 kHz source.
// - Core clock select zero always stops RC oscillator 1.
// - Sleep halts the core system clock.
// - Sleep instruction sets global interrupt enable and, with no interrupt pending or active, halts the core in the same cycle.
// - Peripherals may interrupt during sleep; they keep running only while peripheral-clock-keep is one or code 00 gives them the 32 kHz sub-clock.
// - Any serviced interrupt or any reset ends sleep.
// - Sleep holds only while no interrupt pending or active bit is set.
// - Peripheral-clock-keep bit decides if peripheral clock runs in sleep.
// - Core and peripheral clocks both halted, with watchdog lock term set, switches off selected oscillator unless it is the 32 kHz one.
// - Selected 32 kHz oscillator runs regardless of peripheral-clock-keep.
// - Oscillator halt is sleep AND clock-keep term AND watchdog lock term.
// - Core select one runs system clock from RC1, zero from selected source.
// - Clock-keep zero halts peripheral clock in sleep, one keeps it.
`timescale 1ns/100ps
`default_nettype none
module oscpd_ctrl (
	input  wire logic                   ref_clk_i,
	input  wire logic                   reset_i,
	input  wire logic                   sc_wr_i,
	input  wire logic [3:0]             sc_wdata_i,
	input  wire logic                   core_clk_sel_i,
	input  wire logic                   periph_clock_keep_i,
	input  wire logic                   watchdog_lock_term_i,
	input  wire logic                   sleep_instr_i,
	input  wire logic                   irq_pending_i,
	input  wire logic                   irq_active_i,
	input  wire logic                   irq_service_i,
	output var  logic                   int_enable_set_o,
	output var  logic                   sleeping_o,
	output var  oscpd_pkg::oscpd_osc_en_t osc_en_o,
	output var  oscpd_pkg::oscpd_pwr_t  pwr_o,
	output var  logic [1:0]             sysclk_src_o,
	output var  logic                   sysclk_from_rc1_o,
	output var  logic                   subclk_from_32k_o,
	output var  logic                   peripheral_subclock_o
);
	import oscpd_pkg::*;
	`include "oscpd_cfg.svh"

	typedef struct packed {
		logic [3:0]    sc;
		oscpd_state_t  state;
		logic          ie_set;
		oscpd_osc_en_t osc_en;
		oscpd_pwr_t    pwr;
		logic [1:0]    src;
		logic          from_rc1;
		logic          sub_32k;
		logic          subclk;
	} oscpd_st_t;

	oscpd_st_t st_q;
	oscpd_st_t st_d;
	logic      div_tick;
	logic      sub_32k_now;

	// Oscillator-select field of the configuration register
	function automatic logic [1:0] os_code(input logic [3:0] sc);
		os_code = {sc[`OSCPD_SC_OSHI_BIT], sc[`OSCPD_SC_OSLO_BIT]};
	endfunction : os_code

	assign sub_32k_now = (os_code(st_q.sc) == `OSCPD_OS_XT32K);

	// Prescaler runs only while the peripheral clock is live
	oscpd_subdiv u_subdiv (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.run_i     (st_q.pwr.periph_clk_en),
		.tick_o    (div_tick)
	);

	always_comb begin
		logic wake;
		logic osc_stop;
		logic [1:0] code;
		wake     = 1'b0;
		osc_stop = 1'b0;
		code     = 2'h0;
		st_d        = st_q;
		st_d.ie_set = 1'b0;

		// Write-only register; bit 2 unused and kept at reset value
		if (sc_wr_i) begin
			st_d.sc = (sc_wdata_i & `OSCPD_SC_WMASK) | (st_q.sc & ~`OSCPD_SC_WMASK);
		end

		// Sleep sequencing; a pending or active interrupt blocks entry
		wake = irq_service_i | irq_pending_i | irq_active_i;
		unique case (st_q.state)
			OSCPD_RUN: begin
				if (sleep_instr_i) begin
					st_d.ie_set = 1'b1;
					if (!(irq_pending_i | irq_active_i)) begin
						st_d.state = OSCPD_SLEEP;
					end
				end
			end
			OSCPD_SLEEP: begin
				if (wake) begin
					st_d.state = OSCPD_RUN;
				end
			end
		endcase

		// Clock gating follows the state being entered
		st_d.pwr.core_clk_en   = (st_d.state == OSCPD_RUN);
		st_d.pwr.periph_clk_en = (st_d.state == OSCPD_RUN) | periph_clock_keep_i;
		// Keep term taken as clock not kept; active-high halt of the lock term
		osc_stop = (st_d.state == OSCPD_SLEEP) & ~periph_clock_keep_i
			& watchdog_lock_term_i;
		st_d.pwr.osc_halt     = osc_stop;
		st_d.pwr.brownout_en  = ~osc_stop;
		st_d.pwr.brownout_low = st_d.sc[`OSCPD_SC_BOT_BIT];

		// Oscillator enables; only the paired source runs
		code = os_code(st_d.sc);
		st_d.osc_en.rc1   = core_clk_sel_i & ~osc_stop;
		st_d.osc_en.rc2   = (code == `OSCPD_OS_RC2) & ~osc_stop;
		st_d.osc_en.xt4m  = (code == `OSCPD_OS_XT4M) & ~osc_stop;
		st_d.osc_en.ext   = (code == `OSCPD_OS_EXT) & ~osc_stop;
		st_d.osc_en.xt32k = (code == `OSCPD_OS_XT32K);

		st_d.src      = code;
		st_d.from_rc1 = core_clk_sel_i;
		st_d.sub_32k  = (code == `OSCPD_OS_XT32K);

		// Sub-clock enable: divided pulse, or level when the 32 kHz path feeds it
		st_d.subclk = sub_32k_now ? st_d.osc_en.xt32k : div_tick;
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			st_q        <= '0;
			st_q.sc     <= `OSCPD_SC_RESET;
			st_q.state  <= OSCPD_RUN;
			st_q.osc_en <= '{rc1: 1'b1, rc2: 1'b0, xt4m: 1'b0, xt32k: 1'b0, ext: 1'b1};
			st_q.pwr    <= '{core_clk_en: 1'b1, periph_clk_en: 1'b1, osc_halt: 1'b0,
				brownout_en: 1'b1, brownout_low: 1'b1};
			st_q.src      <= `OSCPD_OS_EXT;
			st_q.from_rc1 <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// All outputs straight from the state register
	assign int_enable_set_o      = st_q.ie_set;
	assign sleeping_o            = (st_q.state == OSCPD_SLEEP);
	assign osc_en_o              = st_q.osc_en;
	assign pwr_o                 = st_q.pwr;
	assign sysclk_src_o          = st_q.src;
	assign sysclk_from_rc1_o     = st_q.from_rc1;
	assign subclk_from_32k_o     = st_q.sub_32k;
	assign peripheral_subclock_o = st_q.subclk;
endmodule : oscpd_ctrl
`default_nettype wire

/* File: core/oscpd_cfg.svh */
// Constants for the oscillator select and power-down control block
`ifndef OSCPD_CFG_SVH
`define OSCPD_CFG_SVH
`define OSCPD_SC_BOT_BIT    3
`define OSCPD_SC_OSHI_BIT   1
`define OSCPD_SC_OSLO_BIT   0
`define OSCPD_SC_RESET      4'hb
`define OSCPD_SC_WMASK      4'hb
`define OSCPD_SUBDIV_LEN    4
`define OSCPD_OS_EXT        2'h3
`define OSCPD_OS_RC2        2'h1
`define OSCPD_OS_XT4M       2'h2
`define OSCPD_OS_XT32K      2'h0
`endif

/* File: core/oscpd_pkg.sv */
// Types for the oscillator select and power-down control block
package oscpd_pkg;
	typedef enum logic [1:0] {
		OSCPD_RUN,
		OSCPD_SLEEP
	} oscpd_state_t;

	// Oscillator run enables, one bit per source
	typedef struct packed {
		logic rc1;
		logic rc2;
		logic xt4m;
		logic xt32k;
		logic ext;
	} oscpd_osc_en_t;

	// Clock gating and detection controls toward the clock tree
	typedef struct packed {
		logic core_clk_en;
		logic periph_clk_en;
		logic osc_halt;
		logic brownout_en;
		logic brownout_low;
	} oscpd_pwr_t;
endpackage : oscpd_pkg

/* File: core/oscpd_subdiv.sv */
// Divide-by-16 enable generator for the peripheral sub-clock
`timescale 1ns/100ps
`default_nettype none
module oscpd_subdiv (
	input  wire logic ref_clk_i,
	input  wire logic reset_i,
	input  wire logic run_i,
	output var  logic tick_o
);
	import oscpd_pkg::*;
	`include "oscpd_cfg.svh"

	typedef struct packed {
		logic [`OSCPD_SUBDIV_LEN-1:0] cnt;
		logic                         tick;
	} oscpd_div_st_t;

	oscpd_div_st_t st_q;
	oscpd_div_st_t st_d;

	// Counter holds while the clock is gated, so no stray tick appears
	always_comb begin
		st_d      = st_q;
		st_d.tick = 1'b0;
		if (run_i) begin
			st_d.cnt  = st_q.cnt + 4'h1;
			st_d.tick = (st_q.cnt == 4'hf);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign tick_o = st_q.tick;
endmodule : oscpd_subdiv
`default_nettype wire

/* File: bench/oscpd_ctrl_assertions.sv */
// Assertion checker for the oscillator and power-down controller
`timescale 1ns/100ps
`default_nettype none
module oscpd_ctrl_assertions (
	input wire logic                     ref_clk_i,
	input wire logic                     reset_i,
	input wire logic                     sleep_instr_i,
	input wire logic                     periph_clock_keep_i,
	input wire logic                     watchdog_lock_term_i,
	input wire logic                     irq_pending_i,
	input wire logic                     irq_active_i,
	input wire logic                     int_enable_set_o,
	input wire logic                     sleeping_o,
	input wire oscpd_pkg::oscpd_osc_en_t osc_en_o,
	input wire oscpd_pkg::oscpd_pwr_t    pwr_o,
	input wire logic [1:0]               sysclk_src_o,
	input wire logic                     sysclk_from_rc1_o,
	input wire logic                     subclk_from_32k_o
);
	import oscpd_pkg::*;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	// Outputs are registered, so inputs are seen through $past
	a_ie_pulse: assert property (sleep_instr_i |=> int_enable_set_o) else $error("no ie");
	a_sleep_cause: assert property ($rose(sleeping_o) |-> $past(sleep_instr_i))
		else $error("sleep without cause");
	a_irq_wake: assert property (sleeping_o && (irq_pending_i || irq_active_i) |=> !sleeping_o)
		else $error("stayed asleep");
	a_core_halt: assert property (sleeping_o |-> !pwr_o.core_clk_en) else $error("core clk");
	a_periph_keep: assert property (sleeping_o |-> pwr_o.periph_clk_en == $past(periph_clock_keep_i))
		else $error("periph clk");
	a_halt_and: assert property (pwr_o.osc_halt == (sleeping_o && !$past(periph_clock_keep_i)
		&& $past(watchdog_lock_term_i))) else $error("osc halt");
	a_deep_stop: assert property (pwr_o.osc_halt |-> !(osc_en_o.rc1 | osc_en_o.rc2 | osc_en_o.xt4m
		| osc_en_o.ext | pwr_o.brownout_en)) else $error("deep stop");
	a_xt32k_run: assert property (sysclk_src_o == 2'h0 |-> osc_en_o.xt32k) else $error("32k");
	a_rc1_stop: assert property (!sysclk_from_rc1_o |-> !osc_en_o.rc1) else $error("rc1");
	a_sub_src: assert property (subclk_from_32k_o == (sysclk_src_o == 2'h0)) else $error("sub");
endmodule : oscpd_ctrl_assertions
bind oscpd_ctrl oscpd_ctrl_assertions u_chk (.ref_clk_i, .reset_i, .sleep_instr_i,
	.periph_clock_keep_i, .watchdog_lock_term_i, .irq_pending_i, .irq_active_i,
	.int_enable_set_o, .sleeping_o, .osc_en_o, .pwr_o, .sysclk_src_o, .sysclk_from_rc1_o,
	.subclk_from_32k_o);
`default_nettype wire

/* File: bench/oscpd_irq_model.sv */
// Interrupt source that wakes a sleeping core after a set delay
`timescale 1ns/100ps
`default_nettype none
module oscpd_irq_model (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       sleeping_i,
	input  wire logic [7:0] delay_i,
	output var  logic       irq_o
);
	logic [7:0] cnt_q;
	// Peripheral keeps counting in sleep, then raises one request
	always_ff @(posedge clk_i) begin
		cnt_q <= (sleeping_i && !reset_i) ? cnt_q + 8'h01 : 8'h00;
		irq_o <= !reset_i && sleeping_i && cnt_q == delay_i;
	end
endmodule : oscpd_irq_model
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the oscillator and power-down controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import oscpd_pkg::*;
	logic ref_clk_i, reset_i, sc_wr_i, core_clk_sel_i, periph_clock_keep_i, sleep_instr_i;
	logic watchdog_lock_term_i, irq_pending_i, irq_active_i, irq_service_i, sleeping_o;
	logic int_enable_set_o, sysclk_from_rc1_o, subclk_from_32k_o, peripheral_subclock_o;
	logic [3:0] sc_wdata_i;
	logic [1:0] sysclk_src_o;
	logic [7:0] dly;
	oscpd_osc_en_t osc_en_o;
	oscpd_pwr_t pwr_o;
	int errors, comparisons;
	oscpd_ctrl u_dut (.*);
	oscpd_irq_model u_irq (.clk_i(ref_clk_i), .reset_i, .sleeping_i(sleeping_o), .delay_i(dly),
		.irq_o(irq_pending_i));
	task automatic chk(string n, logic [7:0] got, logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, exp, got);
		end
	endtask : chk
	task automatic print_verdict();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// Write, then keep three quiet cycles before any sleep
	task automatic sc_write(logic [3:0] d);
		sc_wr_i = 1;
		sc_wdata_i = d;
		@(negedge ref_clk_i);
		sc_wr_i = 0;
		repeat (3) @(negedge ref_clk_i);
	endtask : sc_write
	task automatic do_sleep(logic e);
		sleep_instr_i = 1;
		@(negedge ref_clk_i);
		sleep_instr_i = 0;
		chk("ie", int_enable_set_o, 1);
		chk("slp", sleeping_o, e);
	endtask : do_sleep
	task automatic wake();
		for (int k = 0; k < 60 && sleeping_o; k++) @(negedge ref_clk_i);
		chk("awake", sleeping_o, 0);
		chk("core_en", pwr_o.core_clk_en, 1);
	endtask : wake
	task automatic t_codes();
		chk("rst", {sysclk_src_o, osc_en_o}, 8'h71);
		for (int i = 0; i < 8; i++) begin
			sc_write({i[2], 1'b1, i[1:0]});
			chk("src", sysclk_src_o, i[1:0]);
			chk("bo_low", pwr_o.brownout_low, i[2]);
			chk("osc", osc_en_o, {1'b1, i[1:0] == 1, i[1:0] == 2, i[1:0] == 0, i[1:0] == 3});
		end
		$display("t_codes done");
	endtask : t_codes
	task automatic t_keep();
		int n;
		n = 0;
		periph_clock_keep_i = 1;
		dly = 8'h28;
		do_sleep(1);
		chk("core_en", pwr_o.core_clk_en, 0);
		chk("per_en", {pwr_o.periph_clk_en, pwr_o.osc_halt}, 2);
		repeat (32) begin
			n += peripheral_subclock_o;
			@(negedge ref_clk_i);
		end
		chk("ticks", n, 2);
		wake();
		irq_active_i = 1;
		do_sleep(0);
		irq_active_i = 0;
		// Far-end timer parked so only the driven wake causes act
		dly = 8'hff;
		do_sleep(1);
		irq_service_i = 1;
		@(negedge ref_clk_i);
		irq_service_i = 0;
		chk("svc_wake", sleeping_o, 0);
		do_sleep(1);
		irq_active_i = 1;
		@(negedge ref_clk_i);
		irq_active_i = 0;
		chk("act_wake", sleeping_o, 0);
		// Reset in mid-sleep must leave sleep and restore defaults
		do_sleep(1);
		reset_i = 1;
		@(negedge ref_clk_i);
		reset_i = 0;
		chk("rst_wake", sleeping_o, 0);
		chk("rst_cfg", {sysclk_src_o, osc_en_o}, 8'h71);
		@(negedge ref_clk_i);
		$display("t_keep done");
	endtask : t_keep
	task automatic t_deep();
		sc_write(4'h0);
		core_clk_sel_i = 0;
		periph_clock_keep_i = 0;
		dly = 8'h04;
		@(negedge ref_clk_i);
		chk("rc1", {sysclk_from_rc1_o, osc_en_o.rc1}, 0);
		do_sleep(1);
		chk("halt", pwr_o.osc_halt, 1);
		chk("osc", {osc_en_o, pwr_o.brownout_en}, 8'h04);
		chk("sub", peripheral_subclock_o, 1);
		wake();
		watchdog_lock_term_i = 0;
		do_sleep(1);
		chk("halt", pwr_o.osc_halt, 0);
		wake();
		$display("t_deep done");
	endtask : t_deep
	initial begin
		ref_clk_i = 0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	// Whole run is about a hundred cycles
	initial begin
		#50000;
		errors++;
		print_verdict();
	end
	initial begin
		{reset_i, core_clk_sel_i, watchdog_lock_term_i} = 3'h7;
		{sc_wr_i, sc_wdata_i, periph_clock_keep_i, sleep_instr_i} = 7'h00;
		{irq_active_i, irq_service_i, dly} = 10'h000;
		repeat (2) @(negedge ref_clk_i);
		reset_i = 0;
		t_codes();
		t_keep();
		t_deep();
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
